/* uart_regs_pkg.sv */
/*
  Constants for the serial status and rate register block.
  Assumes a 32-bit APB master at byte addresses, one word per register.
*/
package uart_regs_pkg;
  // Byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_RXHOLD = 8'h18;
  localparam logic [7:0] ADDR_TXHOLD = 8'h1C;
  localparam logic [7:0] ADDR_BAUD = 8'h20;
  localparam logic [7:0] ADDR_RXTIMEOUT = 8'h24;
  localparam logic [7:0] ADDR_GUARD = 8'h28;
  localparam logic [7:0] ADDR_RATIO = 8'h40;
  localparam logic [7:0] ADDR_ERRCNT = 8'h44;
  localparam logic [7:0] ADDR_IRFILTER = 8'h4C;
  // Command bits in the control register
  localparam int CMD_TX_EN = 6;
  localparam int CMD_TX_DIS = 7;
  localparam int CMD_STATUS_CLR = 8;
  localparam int CMD_START_TO = 11;
  localparam int CMD_REPEAT_CLR = 13;
  localparam int CMD_NEGACK_CLR = 14;
  // Mode register: smart-card select
  localparam int MODE_SMARTCARD = 0;
  // Status bit positions
  localparam int ST_RECEIVER_READY_FLAG = 0;
  localparam int ST_TRANSMITTER_READY_FLAG = 1;
  localparam int ST_FRAME = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_TIMEOUT = 8;
  localparam int ST_TXIDLE = 9;
  localparam int ST_REPEAT = 10;
  localparam int ST_TXDMA = 11;
  localparam int ST_RXDMA = 12;
  localparam int ST_NEGACK = 13;
  localparam int ST_CHG_LSB = 16;
  localparam int ST_IMG_LSB = 20;
  // Holding register fields
  localparam int CHAR_W = 9;
  localparam int SYNC_BIT = 15;
  // Rate fields
  localparam int DIV_W = 16;
  localparam int FRAC_LSB = 16;
  localparam int FRAC_W = 3;
  localparam int GUARD_W = 8;
  localparam int RATIO_W = 11;
  localparam logic [10:0] RATIO_RESET = 11'h174;
  localparam int CNT_W = 8;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [2:0] FRAC_LAST = 3'h7;
endpackage : uart_regs_pkg

/* uart_status_and_rate_registers.sv */
/*
  Serial status flags, holding registers and rate generators on APB.
  Assumes receiver/transmitter cores report events as one-cycle pulses,
  the modem and DMA levels are synchronous to clk_sys.
*/
// What this block does
// - Stop bit sampled low sets framing flag until status clear command.
// - Failed parity check sets parity flag until status clear command.
// - Timeout flag sets after start-timeout expiry; stays clear if timeout zero.
// - Transmitter idle only when both holding and shift empty, and enabled.
// - Reaching maximum repetitions sets repeat flag until its clear command.
// - Transmit DMA empty status follows that channel's level.
// - Receive DMA full status follows that channel's level.
// - Any negative acknowledge sets flag until its clear command.
// - Modem input toggle sets change flag; status read clears them all.
// - Status shows current levels of the four modem inputs.
// - Receive holding bits 8..0 give last received character.
// - Receive holding bit 15 marks command character versus data.
// - Transmit holding bit 15 selects command or data sync delimiter.
// - Divider zero stops baud clock; else clock divided by 16 and divider.
// - Fraction zero disables fractional step; 1..7 adds eighths.
// - Timeout zero disables; else delay is value times bit period.
// - Guard zero disables; else idle gap of value bit periods.
// - Smart-card baud is serial clock divided by ratio; resets to 0x174.
// - Smart-card ratio zero produces no baud output.
// - Smart-card errors count in 8 bits; reading clears the counter.
// - Filter field configures infrared demodulator glitch filter.
`timescale 1ns/1ns
`default_nettype none
module uart_status_and_rate_registers (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver core events
  input wire logic rxCharValid,
  input wire logic [8:0] rxCharIn,
  input wire logic rxCharIsCommand,
  input wire logic rxStopLow,
  input wire logic rxParityFail,
  input wire logic rxActivity,
  // Transmitter and smart-card events
  input wire logic txShiftEmpty,
  input wire logic txCharTaken,
  input wire logic repeatLimitHit,
  input wire logic negAckSeen,
  input wire logic smartcardError,
  input wire logic scardClkTick,
  // DMA channel levels
  input wire logic txDmaEmpty,
  input wire logic rxDmaFull,
  // Modem inputs: ring, set ready, carrier, clear to send
  input wire logic [3:0] modemIn,
  // To transmit and receive cores
  output logic [8:0] outgoingCharacter,
  output logic outgoingCommandMarker,
  output logic txCharPending,
  output logic baudTick,
  output logic sampleTick,
  output logic guardActive,
  output logic [7:0] irFilter
);
  localparam int DW = uart_regs_pkg::DIV_W;
  function automatic logic [DW-1:0] incr(input logic [DW-1:0] v);
    incr = v + 16'h0001;
  endfunction : incr
  logic apbWr, apbRd;
  logic [31:0] statusWord, rdMux, cmd;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apbWr = psel & penable & pwrite;
  assign apbRd = psel & penable & ~pwrite;
  assign cmd = (apbWr && paddr == uart_regs_pkg::ADDR_CONTROL) ? pwdata
             : 32'h0000_0000;
  // Configuration registers
  logic [DW-1:0] divider_q, timeout_q;
  logic [2:0] fraction_q;
  logic [7:0] guard_q, irFilter_q;
  logic [10:0] ratio_q;
  logic smartcard_q, txEnable_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      divider_q <= 16'h0000;
      fraction_q <= 3'h0;
      timeout_q <= 16'h0000;
      guard_q <= 8'h00;
      ratio_q <= uart_regs_pkg::RATIO_RESET;
      irFilter_q <= 8'h00;
      smartcard_q <= 1'b0;
    end
    else if (apbWr)
    begin
      case (paddr)
        uart_regs_pkg::ADDR_BAUD:
        begin
          divider_q <= pwdata[DW-1:0];
          fraction_q <= pwdata[uart_regs_pkg::FRAC_LSB +: 3];
        end
        uart_regs_pkg::ADDR_RXTIMEOUT: timeout_q <= pwdata[DW-1:0];
        uart_regs_pkg::ADDR_GUARD: guard_q <= pwdata[7:0];
        uart_regs_pkg::ADDR_RATIO: ratio_q <= pwdata[10:0];
        uart_regs_pkg::ADDR_IRFILTER: irFilter_q <= pwdata[7:0];
        uart_regs_pkg::ADDR_MODE:
          smartcard_q <= pwdata[uart_regs_pkg::MODE_SMARTCARD];
        default: ;
      endcase
    end
  end
  assign irFilter = irFilter_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      txEnable_q <= 1'b0;
    else if (cmd[uart_regs_pkg::CMD_TX_DIS])
      txEnable_q <= 1'b0;
    else if (cmd[uart_regs_pkg::CMD_TX_EN])
      txEnable_q <= 1'b1;
  end
  // Baud generator: sample tick every divider (+fraction), bit tick per 16
  logic [DW-1:0] divCnt_q;
  logic [2:0] fracAcc_q;
  logic [3:0] ovsCnt_q;
  logic [10:0] ratioCnt_q;
  logic sample_q, baud_q, fracExtra;
  logic [3:0] fracSum;
  assign fracSum = {1'b0, fracAcc_q} + {1'b0, fraction_q};
  assign fracExtra = fracSum[3];
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      divCnt_q <= 16'h0000;
      fracAcc_q <= 3'h0;
      ovsCnt_q <= 4'h0;
      ratioCnt_q <= 11'h000;
      sample_q <= 1'b0;
      baud_q <= 1'b0;
    end
    else
    begin
      sample_q <= 1'b0;
      baud_q <= 1'b0;
      if (smartcard_q)
      begin
        // Ratio zero: generator idle, no output
        if (ratio_q == 11'h000)
          ratioCnt_q <= 11'h000;
        else if (scardClkTick)
        begin
          if (ratioCnt_q + 11'h001 >= ratio_q)
          begin
            ratioCnt_q <= 11'h000;
            baud_q <= 1'b1;
          end
          else
            ratioCnt_q <= ratioCnt_q + 11'h001;
        end
      end
      else if (divider_q == 16'h0000)
      begin
        divCnt_q <= 16'h0000;
        ovsCnt_q <= 4'h0;
      end
      // Fraction stretches one period per carry, averaging fraction/8 extra;
      // 17 bits so that divider 65535 plus a carry does not wrap
      else if ({1'b0, divCnt_q} + 17'h0_0001
        >= {1'b0, divider_q} + {16'h0000, fracExtra})
      begin
        divCnt_q <= 16'h0000;
        fracAcc_q <= fracSum[2:0];
        sample_q <= 1'b1;
        ovsCnt_q <= ovsCnt_q + 4'h1;
        if (ovsCnt_q == uart_regs_pkg::OVS_LAST)
          baud_q <= 1'b1;
      end
      else
        divCnt_q <= incr(divCnt_q);
    end
  end
  assign baudTick = baud_q;
  assign sampleTick = sample_q;
  // Receive holding register
  logic [8:0] rxChar_q;
  logic rxCmd_q, rxReady_q, rhrRead;
  assign rhrRead = apbRd && paddr == uart_regs_pkg::ADDR_RXHOLD;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rxChar_q <= 9'h000;
      rxCmd_q <= 1'b0;
      rxReady_q <= 1'b0;
    end
    else if (rxCharValid)
    begin
      rxChar_q <= rxCharIn;
      rxCmd_q <= rxCharIsCommand;
      rxReady_q <= 1'b1;
    end
    else if (rhrRead)
      rxReady_q <= 1'b0;
  end
  // Transmit holding register
  logic [8:0] txChar_q;
  logic txCmd_q, txPend_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      txChar_q <= 9'h000;
      txCmd_q <= 1'b0;
      txPend_q <= 1'b0;
    end
    else if (apbWr && paddr == uart_regs_pkg::ADDR_TXHOLD)
    begin
      txChar_q <= pwdata[8:0];
      txCmd_q <= pwdata[uart_regs_pkg::SYNC_BIT];
      txPend_q <= 1'b1;
    end
    else if (txCharTaken || !txEnable_q)
      txPend_q <= 1'b0;
  end
  assign outgoingCharacter = txChar_q;
  assign outgoingCommandMarker = txCmd_q;
  assign txCharPending = txPend_q;
  // Guard gap after each character
  logic [7:0] guardCnt_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      guardCnt_q <= 8'h00;
    else if (txCharTaken && guard_q != 8'h00)
      guardCnt_q <= guard_q;
    else if (baud_q && guardCnt_q != 8'h00)
      guardCnt_q <= guardCnt_q - 8'h01;
  end
  assign guardActive = guardCnt_q != 8'h00;
  // Receive timeout in bit periods, restarted by activity
  logic [DW-1:0] toCnt_q;
  logic toArmed_q, timeout_q_flag;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      toCnt_q <= 16'h0000;
      toArmed_q <= 1'b0;
      timeout_q_flag <= 1'b0;
    end
    else if (timeout_q == 16'h0000)
    begin
      toArmed_q <= 1'b0;
      timeout_q_flag <= 1'b0;
    end
    else if (cmd[uart_regs_pkg::CMD_START_TO])
    begin
      toCnt_q <= 16'h0000;
      toArmed_q <= 1'b1;
      timeout_q_flag <= 1'b0;
    end
    else if (toArmed_q)
    begin
      if (rxActivity)
        toCnt_q <= 16'h0000;
      else if (baud_q)
      begin
        if (incr(toCnt_q) >= timeout_q)
        begin
          timeout_q_flag <= 1'b1;
          toArmed_q <= 1'b0;
        end
        else
          toCnt_q <= incr(toCnt_q);
      end
    end
  end
  // Sticky error flags; a new event wins over the clear
  logic frame_q, parity_q, repeat_q, negAck_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_q <= 1'b0;
      parity_q <= 1'b0;
      repeat_q <= 1'b0;
      negAck_q <= 1'b0;
    end
    else
    begin
      frame_q <= rxStopLow
        | (frame_q & ~cmd[uart_regs_pkg::CMD_STATUS_CLR]);
      parity_q <= rxParityFail
        | (parity_q & ~cmd[uart_regs_pkg::CMD_STATUS_CLR]);
      repeat_q <= repeatLimitHit
        | (repeat_q & ~cmd[uart_regs_pkg::CMD_REPEAT_CLR]);
      negAck_q <= negAckSeen
        | (negAck_q & ~cmd[uart_regs_pkg::CMD_NEGACK_CLR]);
    end
  end
  // Modem change detect; first edge after reset only learns the levels
  logic [3:0] modemPrev_q, change_q;
  logic statusRead, modemSeen_q;
  assign statusRead = apbRd && paddr == uart_regs_pkg::ADDR_STATUS;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      modemPrev_q <= 4'h0;
      change_q <= 4'h0;
      modemSeen_q <= 1'b0;
    end
    else
    begin
      modemPrev_q <= modemIn;
      modemSeen_q <= 1'b1;
      change_q <= ((modemIn ^ modemPrev_q) & {4{modemSeen_q}})
        | (change_q & {4{~statusRead}});
    end
  end

  // Smart-card error counter, cleared by read; increment wins
  logic [7:0] errCnt_q;
  logic nerRead;
  assign nerRead = apbRd && paddr == uart_regs_pkg::ADDR_ERRCNT;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      errCnt_q <= 8'h00;
    else if (nerRead)
      errCnt_q <= smartcardError ? 8'h01 : 8'h00;
    else if (smartcardError && errCnt_q != 8'hFF)
      errCnt_q <= errCnt_q + 8'h01;
  end

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[uart_regs_pkg::ST_RECEIVER_READY_FLAG] = rxReady_q;
    statusWord[uart_regs_pkg::ST_TRANSMITTER_READY_FLAG] = txEnable_q & ~txPend_q;
    statusWord[uart_regs_pkg::ST_FRAME] = frame_q;
    statusWord[uart_regs_pkg::ST_PARITY] = parity_q;
    statusWord[uart_regs_pkg::ST_TIMEOUT] = timeout_q_flag;
    statusWord[uart_regs_pkg::ST_TXIDLE] =
      txEnable_q & ~txPend_q & txShiftEmpty;
    statusWord[uart_regs_pkg::ST_REPEAT] = repeat_q;
    statusWord[uart_regs_pkg::ST_TXDMA] = txDmaEmpty;
    statusWord[uart_regs_pkg::ST_RXDMA] = rxDmaFull;
    statusWord[uart_regs_pkg::ST_NEGACK] = negAck_q;
    statusWord[uart_regs_pkg::ST_CHG_LSB +: 4] = change_q;
    statusWord[uart_regs_pkg::ST_IMG_LSB +: 4] = modemIn;
  end

  // Unused bits and write-only registers read as zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (paddr)
      uart_regs_pkg::ADDR_STATUS: rdMux = statusWord;
      uart_regs_pkg::ADDR_RXHOLD:
      begin
        rdMux[8:0] = rxChar_q;
        rdMux[uart_regs_pkg::SYNC_BIT] = rxCmd_q;
      end
      uart_regs_pkg::ADDR_BAUD:
      begin
        rdMux[DW-1:0] = divider_q;
        rdMux[uart_regs_pkg::FRAC_LSB +: 3] = fraction_q;
      end
      uart_regs_pkg::ADDR_RXTIMEOUT: rdMux[DW-1:0] = timeout_q;
      uart_regs_pkg::ADDR_GUARD: rdMux[7:0] = guard_q;
      uart_regs_pkg::ADDR_RATIO: rdMux[10:0] = ratio_q;
      uart_regs_pkg::ADDR_ERRCNT: rdMux[7:0] = errCnt_q;
      uart_regs_pkg::ADDR_IRFILTER: rdMux[7:0] = irFilter_q;
      uart_regs_pkg::ADDR_MODE:
        rdMux[uart_regs_pkg::MODE_SMARTCARD] = smartcard_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end
  assign prdata = apbRd ? rdMux : 32'h0000_0000;
endmodule : uart_status_and_rate_registers
`default_nettype wire

/* uart_regs_assertions.sv */
/*
  Checker on the register block's ports.
  Assumes the bind below reaches the block.
*/
`timescale 1ns/1ns
`default_nettype none
module uart_regs_assertions (
  // Clock and bus
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Sideband
  input wire logic smartcardError,
  input wire logic txDmaEmpty,
  input wire logic [3:0] modemIn,
  input wire logic [8:0] outgoingCharacter,
  input wire logic outgoingCommandMarker,
  input wire logic baudTick,
  input wire logic [7:0] irFilter
);
  logic rd;
  logic wr;
  logic rdSt;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite;
  assign rdSt = rd && paddr == 8'h14;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  AST_TX_DMA: assert property (
    rdSt && $stable(txDmaEmpty) |-> prdata[11] == txDmaEmpty)
    else $error("dma empty image wrong");
  AST_MODEM_IMAGE: assert property (
    rdSt && $stable(modemIn) |-> prdata[23:20] == modemIn)
    else $error("modem image wrong");
  AST_CHANGE_CLEAR: assert property (
    rdSt && $stable(modemIn) ##1 $stable(modemIn)[*3] ##0 rdSt
    |-> prdata[19:16] == 4'h0) else $error("change flags kept");
  AST_TX_HOLD: assert property (
    wr && paddr == 8'h1C |=> outgoingCommandMarker == $past(pwdata[15])
    && outgoingCharacter == $past(pwdata[8:0]))
    else $error("tx holding not loaded");
  AST_IR_FILTER: assert property (
    wr && paddr == 8'h4C |=> irFilter == $past(pwdata[7:0]))
    else $error("filter not loaded");
  AST_ERR_CLEAR: assert property (
    rd && paddr == 8'h44 && !smartcardError ##1 !smartcardError[*3]
    ##0 rd && paddr == 8'h44 |-> prdata[7:0] == 8'h0)
    else $error("error count not cleared");
  AST_UNMAPPED: assert property (
    rd && !(paddr inside {8'h00, 8'h04, 8'h14, 8'h18, 8'h1C, 8'h20,
    8'h24, 8'h28, 8'h40, 8'h44, 8'h4C}) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RX_HOLD_UNUSED: assert property (
    rd && paddr == 8'h18 |-> prdata[31:16] == 16'h0
    && prdata[14:9] == 6'h0) else $error("rx holding spare bits set");
  COV_FRAME: cover property (rdSt && prdata[6]);
  COV_ERRCNT: cover property (rd && paddr == 8'h44 && prdata[0]);
  COV_BAUD: cover property (baudTick);
endmodule : uart_regs_assertions
bind uart_status_and_rate_registers uart_regs_assertions
  uart_regs_assertions_i (.clk_sys, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .smartcardError, .txDmaEmpty, .modemIn,
  .outgoingCharacter, .outgoingCommandMarker, .baudTick, .irFilter);
`default_nettype wire

/* serial_peer_model.sv */
/*
  Transmit core stand-in: takes the held character, then shifts it.
  Assumes txCharPending is registered by the block.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
  // Clock, reset, pace
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slowMode,
  // Block side
  input wire logic txCharPending,
  output logic txCharTaken,
  output logic txShiftEmpty
);
  int waitCnt_q;
  int shiftCnt_q;
  assign txShiftEmpty = shiftCnt_q == 0;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      waitCnt_q <= 0;
      shiftCnt_q <= 0;
      txCharTaken <= 1'h0;
    end
    else
    begin
      txCharTaken <= 1'h0;
      if (shiftCnt_q > 0)
        shiftCnt_q <= shiftCnt_q - 1;
      // Slow pace keeps the holding register full for a while
      else if (txCharPending && !txCharTaken)
      begin
        waitCnt_q <= waitCnt_q + 1;
        if (waitCnt_q >= (slowMode ? 6 : 0))
        begin
          txCharTaken <= 1'h1;
          shiftCnt_q <= 20;
          waitCnt_q <= 0;
        end
      end
    end
  end
endmodule : serial_peer_model
`default_nettype wire

/* tb.sv */
/*
  Self-checking bench for the status and rate register block.
  Assumes the checker and the transmit stand-in compile first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, irFilter;
  logic [31:0] pwdata, prdata, rdata, v, expSt;
  logic rxCharIsCommand, rxActivity, scardClkTick, slowMode;
  logic txDmaEmpty, rxDmaFull, outgoingCommandMarker, txCharPending;
  logic baudTick, sampleTick, guardActive, txShiftEmpty, txCharTaken;
  logic [8:0] rxCharIn, outgoingCharacter;
  logic [5:0] ev;
  logic [3:0] modemIn;
  wire rxCharValid, rxStopLow, rxParityFail;
  wire repeatLimitHit, negAckSeen, smartcardError;
  int mismatches, nTests, seed, i, n;
  localparam logic [7:0] RW_A [5] = '{8'h20, 8'h24, 8'h28, 8'h40, 8'h4C};
  localparam logic [31:0] RW_M [5] = '{32'h7FFFF, 32'hFFFF, 32'hFF,
    32'h7FF, 32'hFF};
  localparam int FLAG_B [4] = '{6, 7, 10, 13};
  localparam int CLR_B [4] = '{8, 8, 13, 14};
  localparam logic [31:0] BAUD_W [4] = '{32'h1, 32'h3, 32'h40001,
    32'h70002};
  assign {rxCharValid, smartcardError, negAckSeen, repeatLimitHit,
    rxParityFail, rxStopLow} = ev;
  uart_status_and_rate_registers uart_status_and_rate_registers_i (
    .clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxCharValid, .rxCharIn, .rxCharIsCommand,
    .rxStopLow, .rxParityFail, .rxActivity, .txShiftEmpty, .txCharTaken,
    .repeatLimitHit, .negAckSeen, .smartcardError, .scardClkTick,
    .txDmaEmpty, .rxDmaFull, .modemIn, .outgoingCharacter,
    .outgoingCommandMarker, .txCharPending, .baudTick, .sampleTick,
    .guardActive, .irFilter);
  serial_peer_model serial_peer_model_i (.clk_sys, .nrst, .slowMode,
    .txCharPending, .txCharTaken, .txShiftEmpty);
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rdata = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'h0, a, 32'h0);
    `CHK(rdata & m, e)
  endtask : rdChk
  task automatic pulse(input int b);
    @(posedge clk_sys);
    ev[b] <= 1'h1;
    @(posedge clk_sys);
    ev[b] <= 1'h0;
  endtask : pulse
  task automatic tickGap(output int g);
    g = 0;
    do @(posedge clk_sys); while (baudTick !== 1'h1);
    do
    begin
      @(posedge clk_sys);
      g++;
    end
    while (baudTick !== 1'h1);
  endtask : tickGap
  task automatic countTicks(output int c);
    c = 0;
    repeat (100)
    begin
      @(posedge clk_sys);
      if (baudTick !== 1'h0 || sampleTick !== 1'h0) c++;
    end
  endtask : countTicks
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ev, rxCharIn, expSt} = '0;
    {rxCharIsCommand, rxActivity, scardClkTick, slowMode} = '0;
    {modemIn, txDmaEmpty, rxDmaFull} = '0;
    mismatches = 0;
    nTests = 0;
    seed = 75;
    nrst = 1'h0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'h1;
    for (i = 0; i < 5; i++)
      rdChk(RW_A[i], 32'hFFFFFFFF, i == 3 ? 32'h174 : 32'h0);
    rdChk(8'h14, 32'h200, 32'h0);
    for (i = 0; i < 5; i++)
    begin
      v = $random(seed);
      apb(1'h1, RW_A[i], v);
      rdChk(RW_A[i], 32'hFFFFFFFF, v & RW_M[i]);
    end
    apb(1'h1, 8'h30, 32'hFFFFFFFF);
    rdChk(8'h30, 32'hFFFFFFFF, 32'h0);
    `CHK(pslverr, 1'h0)
    `CHK(pready, 1'h1)
    for (i = 0; i < 4; i++)
    begin
      pulse(i);
      expSt[FLAG_B[i]] = 1'h1;
    end
    rdChk(8'h14, 32'h24C0, expSt);
    // One command may clear several flags at once
    for (i = 0; i < 4; i++)
    begin
      apb(1'h1, 8'h00, 32'h1 << CLR_B[i]);
      for (n = 0; n < 4; n++)
        if (CLR_B[n] == CLR_B[i]) expSt[FLAG_B[n]] = 1'h0;
      rdChk(8'h14, 32'h24C0, expSt);
    end
    repeat (3) pulse(4);
    rdChk(8'h44, 32'hFFFFFFFF, 32'h3);
    rdChk(8'h44, 32'hFFFFFFFF, 32'h0);
    v = $random(seed) | 32'h1;
    modemIn <= v[3:0];
    txDmaEmpty <= 1'h1;
    repeat (3) @(posedge clk_sys);
    rdChk(8'h14, 32'hFF1800, {v[3:0], v[3:0], 16'h800});
    {rxDmaFull, txDmaEmpty} <= 2'h2;
    repeat (3) @(posedge clk_sys);
    rdChk(8'h14, 32'hFF1800, {v[3:0], 4'h0, 16'h1000});
    rdChk(8'h14, 32'hF0000, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      v = $random(seed);
      rxCharIn <= v[8:0];
      rxCharIsCommand <= i[0];
      pulse(5);
      v = {16'h0, i[0], 6'h0, v[8:0]};
      rdChk(8'h18, 32'hFFFFFFFF, v);
    end
    apb(1'h1, 8'h00, 32'h40);
    repeat (30) @(posedge clk_sys);
    rdChk(8'h14, 32'h200, 32'h200);
    slowMode <= 1'h1;
    v = $random(seed);
    apb(1'h1, 8'h1C, v);
    @(posedge clk_sys);
    `CHK(outgoingCharacter, v[8:0])
    `CHK(outgoingCommandMarker, v[15])
    rdChk(8'h14, 32'h200, 32'h0);
    repeat (40) @(posedge clk_sys);
    rdChk(8'h14, 32'h200, 32'h200);
    apb(1'h1, 8'h00, 32'h80);
    rdChk(8'h14, 32'h200, 32'h0);
    // First gap after a rate change may be partial, so it is skipped
    for (i = 0; i < 4; i++)
    begin
      apb(1'h1, 8'h20, BAUD_W[i]);
      tickGap(n);
      tickGap(n);
      `CHK(n, 16 * BAUD_W[i][15:0] + 2 * BAUD_W[i][18:16])
    end
    apb(1'h1, 8'h20, 32'h0);
    repeat (2) @(posedge clk_sys);
    countTicks(n);
    `CHK(n, 0)
    apb(1'h1, 8'h20, 32'h1);
    apb(1'h1, 8'h24, 32'h2);
    apb(1'h1, 8'h00, 32'h800);
    rdChk(8'h14, 32'h100, 32'h0);
    repeat (60) @(posedge clk_sys);
    rdChk(8'h14, 32'h100, 32'h100);
    apb(1'h1, 8'h24, 32'h0);
    rdChk(8'h14, 32'h100, 32'h0);
    apb(1'h1, 8'h28, 32'h2);
    apb(1'h1, 8'h00, 32'h40);
    slowMode <= 1'h0;
    apb(1'h1, 8'h1C, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(guardActive, 1'h1)
    repeat (40) @(posedge clk_sys);
    `CHK(guardActive, 1'h0)
    apb(1'h1, 8'h04, 32'h1);
    apb(1'h1, 8'h40, 32'h3);
    scardClkTick <= 1'h1;
    tickGap(n);
    tickGap(n);
    `CHK(n, 3)
    apb(1'h1, 8'h40, 32'h0);
    repeat (2) @(posedge clk_sys);
    countTicks(n);
    `CHK(n, 0)
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict;
  end
endmodule : tb
`default_nettype wire
